//--- dsp_slice_pkg.sv
// Shared types and constants for the multiply-accumulate slice.
// Assumes a single clock domain and an AHB-Lite master for configuration.
package dsp_slice_pkg;

  // ---------------------------------------------------------------
  // Datapath widths
  // ---------------------------------------------------------------
  localparam int A_W = 27;
  localparam int B_W = 18;
  localparam int P_W = 48;
  localparam int LANE_W = 12;
  localparam int XOR_BITS = 8;
  localparam int STEP_W = 32;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses) and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_PAT_LO = 8'h04;
  localparam logic [7:0] OFF_PAT_HI = 8'h08;
  localparam logic [7:0] OFF_MASK_LO = 8'h0c;
  localparam logic [7:0] OFF_MASK_HI = 8'h10;
  localparam logic [7:0] OFF_STEP = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_RES_LO = 8'h1c;
  localparam logic [7:0] OFF_RES_HI = 8'h20;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [47:0] PAT_RST = 48'h0;
  localparam logic [47:0] MASK_RST = 48'h0;
  localparam logic [31:0] STEP_RST = 32'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ---------------------------------------------------------------
  // Modes and operations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SIMD_ONE48, SIMD_TWO24, SIMD_FOUR12} simd_e;
  typedef enum logic [1:0] {XW_12, XW_24, XW_48, XW_96} xw_e;
  typedef enum logic [2:0] {OP_ADD, OP_SUB, OP_LOGIC, OP_CNT_UP, OP_CNT_DN} alu_op_e;
  typedef enum logic [3:0] {
    FN_AND, FN_OR, FN_XOR, FN_XNOR, FN_NAND, FN_NOR, FN_ANDN, FN_ORN, FN_NOTX, FN_PASSX
  } logic_fn_e;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // Configuration register layout, bit 0 is in_reg.
  typedef struct packed {
    logic chain;
    xw_e xw;
    simd_e simd;
    logic q_reg;
    logic m_reg;
    logic in_reg;
  } cfg_s;

  typedef struct packed {
    logic bypass;
    logic preadd;
    logic pre_sub;
    logic acc;
    alu_op_e op;
    logic_fn_e fn;
  } ctrl_s;

  typedef struct packed {
    logic ce_in;
    logic rst_in;
    logic ce_m;
    logic rst_m;
    logic ce_p;
    logic rst_p;
    logic ce_q;
    logic rst_q;
  } stage_s;

  typedef struct packed {
    logic [A_W-1:0] a;
    logic [B_W-1:0] b;
    logic [A_W-1:0] d;
    logic [P_W-1:0] ab;
    logic [P_W-1:0] c;
    ctrl_s ctrl;
  } opnd_s;

  typedef struct packed {
    logic [P_W-1:0] prod;
    logic [P_W-1:0] ab;
    logic [P_W-1:0] c;
    ctrl_s ctrl;
  } mid_s;

  // Status register layout, bit 0 is match.
  typedef struct packed {
    logic [XOR_BITS-1:0] xr;
    logic m96;
    logic mb;
    logic m;
  } flags_s;

endpackage : dsp_slice_pkg

//--- pipe_stage.sv
// Optional pipeline register with its own clock enable and synchronous clear.
// Assumes en is static configuration; when low the stage is a wire.
`timescale 1ns/1ns
module pipe_stage #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic ce,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // RL11 per-stage enable and clear.
  always_comb begin
    q_nxt = q_r;
    if (srst) begin
      q_nxt = '0;
    end else if (ce) begin
      q_nxt = d;
    end
  end

  // Bypassed stages still clock, so turning one on later starts from known data.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = en ? q_r : d;

  a_stage_clear: assert property (@(posedge clk) disable iff (!rst_n) // RL11
    srst |=> q_r == '0) else $error("stage clear not applied");
  a_stage_hold: assert property (@(posedge clk) disable iff (!rst_n) // RL11
    !srst && !ce |=> $stable(q_r)) else $error("stage moved without enable");

endmodule : pipe_stage

//--- dsp_slice.sv
// Multiply-accumulate slice: pre-adder, signed multiplier, SIMD adder,
// logic unit, wide XOR and pattern detector, with AHB-Lite configuration.
// Assumes operands and controls come from fabric logic on the same clock.
//
// Function
// RL1 - A signed 27 by 18 multiplier gives the full-precision product.
// RL2 - A 48-bit accumulator adds each new result to its registered value.
// RL3 - A run-time control skips the multiplier and adds two 48-bit operands.
// RL4 - The adder splits into two 24-bit or four 12-bit lanes with no carry between them.
// RL5 - The logic unit gives one of ten bitwise functions of the two operands.
// RL6 - A pre-adder sums or subtracts two operands ahead of the multiplier.
// RL7 - A wide XOR reduces the operands in 12, 24, 48 or 96-bit groups.
// RL8 - A pattern detector flags a masked match of the result against a pattern.
// RL9 - Chained with the logic unit, the detector spans 96 bits over two results.
// RL10 - The accumulator counts up or down by a set step on each enabled edge.
// RL11 - Each input, product and result stage is optional, with enable and clear; the result stage is always registered here.
// RL12 - Fabric holds controls with their operands and allows for the latency.
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module dsp_slice
  import dsp_slice_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire opnd_s opnd_in,
  input wire stage_s stage_in,
  output logic [P_W-1:0] p_out,
  output flags_s flags_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    cfg_s cfg;
    logic [P_W-1:0] pat;
    logic [P_W-1:0] mask;
    logic [STEP_W-1:0] step;
    logic [P_W-1:0] p;
    flags_s fl;
    logic [P_W-1:0] q;
    flags_s qfl;
    logic ah_act;
    logic ah_wr;
    logic [7:0] ah_addr;
    logic [31:0] rdata;
  } st_s;

  st_s st_r;
  st_s st_nxt;
  opnd_s in_q;
  mid_s m_d;
  mid_s m_q;
  logic signed [A_W:0] pre;
  logic signed [A_W+B_W:0] prod46;
  logic [P_W-1:0] x;
  logic [P_W-1:0] y;
  logic [P_W-1:0] z;
  logic [P_W-1:0] r;
  logic match;
  logic [XOR_BITS-1:0] xr;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Ripple add or subtract with the carry restarted at each lane edge.
  function automatic logic [P_W-1:0] lane_add(input logic [P_W-1:0] a,
                                              input logic [P_W-1:0] b,
                                              input logic sub,
                                              input simd_e m);
    logic c;
    logic brk;
    logic [P_W-1:0] bb;
    logic [P_W-1:0] s;
    bb = sub ? ~b : b;
    c = sub;
    s = '0;
    for (int i = 0; i < P_W; i++) begin
      brk = (m == SIMD_FOUR12 && i % LANE_W == 0) || (m == SIMD_TWO24 && i % (2 * LANE_W) == 0);
      // RL4 no carry across lanes.
      if (i != 0 && brk) begin
        c = sub;
      end
      s[i] = a[i] ^ bb[i] ^ c;
      c = (a[i] & bb[i]) | (c & (a[i] ^ bb[i]));
    end
    return s;
  endfunction : lane_add

  function automatic logic [P_W-1:0] logic_unit(input logic_fn_e fn,
                                                input logic [P_W-1:0] a,
                                                input logic [P_W-1:0] b);
    logic [P_W-1:0] o;
    case (fn)
      FN_AND: o = a & b;
      FN_OR: o = a | b;
      FN_XOR: o = a ^ b;
      FN_XNOR: o = ~(a ^ b);
      FN_NAND: o = ~(a & b);
      FN_NOR: o = ~(a | b);
      FN_ANDN: o = a & ~b;
      FN_ORN: o = a | ~b;
      FN_NOTX: o = ~a;
      FN_PASSX: o = a;
      default: o = '0;
    endcase
    return o;
  endfunction : logic_unit

  // Group width is 12 shifted by the width code; unused outputs stay zero.
  function automatic logic [XOR_BITS-1:0] xor_reduce(input xw_e w,
                                                    input logic [2*P_W-1:0] v);
    logic [XOR_BITS-1:0] o;
    int g;
    o = '0;
    g = LANE_W << w;
    for (int i = 0; i < 2 * P_W; i++) begin
      o[i / g] = o[i / g] ^ v[i];
    end
    return o;
  endfunction : xor_reduce

  function automatic logic [P_W-1:0] sext(input logic [A_W-1:0] v);
    return {{(P_W - A_W){v[A_W-1]}}, v};
  endfunction : sext

  function automatic logic hit(input logic [P_W-1:0] v,
                               input logic [P_W-1:0] pat,
                               input logic [P_W-1:0] mask);
    return ((v ^ pat) & ~mask) == '0;
  endfunction : hit

  function automatic logic [31:0] read_reg(input logic [7:0] a, input st_s s);
    logic [31:0] o;
    case (a)
      OFF_CFG: o = 32'(s.cfg);
      OFF_PAT_LO: o = s.pat[31:0];
      OFF_PAT_HI: o = 32'(s.pat[P_W-1:32]);
      OFF_MASK_LO: o = s.mask[31:0];
      OFF_MASK_HI: o = 32'(s.mask[P_W-1:32]);
      OFF_STEP: o = s.step;
      OFF_STATUS: o = 32'(s.fl);
      OFF_RES_LO: o = s.p[31:0];
      OFF_RES_HI: o = 32'(s.p[P_W-1:32]);
      default: o = 32'h0;
    endcase
    return o;
  endfunction : read_reg

  // ---------------------------------------------------------------
  // Input and product stages
  // ---------------------------------------------------------------
  // RL12 controls travel in the same stage as their operands.
  pipe_stage #(.W($bits(opnd_s))) u_in_stage (
    .clk(clk),
    .rst_n(rst_n),
    .en(st_r.cfg.in_reg),
    .ce(stage_in.ce_in),
    .srst(stage_in.rst_in),
    .d(opnd_in),
    .q(in_q)
  );

  // RL6 pre-adder ahead of the multiplier.
  always_comb begin
    pre = (A_W + 1)'($signed(in_q.a));
    // Widening both terms first keeps the carry out of the 27-bit sum.
    if (in_q.ctrl.preadd) begin
      pre = in_q.ctrl.pre_sub ? (A_W + 1)'($signed(in_q.d)) - (A_W + 1)'($signed(in_q.a))
                              : (A_W + 1)'($signed(in_q.d)) + (A_W + 1)'($signed(in_q.a));
    end
  end

  // RL1 full-precision signed product, sign-extended to the result width.
  assign prod46 = pre * $signed(in_q.b);
  assign m_d = '{prod: P_W'(prod46), ab: in_q.ab, c: in_q.c, ctrl: in_q.ctrl};

  pipe_stage #(.W($bits(mid_s))) u_m_stage (
    .clk(clk),
    .rst_n(rst_n),
    .en(st_r.cfg.m_reg),
    .ce(stage_in.ce_m),
    .srst(stage_in.rst_m),
    .d(m_d),
    .q(m_q)
  );

  // ---------------------------------------------------------------
  // Arithmetic and logic unit
  // ---------------------------------------------------------------
  always_comb begin
    // RL3 bypass routes the wide operand where the product would go.
    x = m_q.ctrl.bypass ? m_q.ab : m_q.prod;
    y = m_q.c;
    // RL2 the registered result feeds back when accumulating.
    z = m_q.ctrl.acc ? st_r.p : '0;
    case (m_q.ctrl.op)
      OP_ADD: r = lane_add(z, lane_add(x, y, 1'b0, st_r.cfg.simd), 1'b0, st_r.cfg.simd);
      OP_SUB: r = lane_add(z, lane_add(x, y, 1'b0, st_r.cfg.simd), 1'b1, st_r.cfg.simd);
      // RL5 bitwise logic of the two operands.
      OP_LOGIC: r = logic_unit(m_q.ctrl.fn, x, y);
      // RL10 counter steps the held result.
      OP_CNT_UP: r = lane_add(st_r.p, P_W'(st_r.step), 1'b0, SIMD_ONE48);
      OP_CNT_DN: r = lane_add(st_r.p, P_W'(st_r.step), 1'b1, SIMD_ONE48);
      default: r = st_r.p;
    endcase
  end

  // RL8 masked compare of the new result against the pattern.
  assign match = hit(r, st_r.pat, st_r.mask);
  // RL7 XOR over both wide operands in the chosen group width.
  assign xr = xor_reduce(st_r.cfg.xw, {x, y});

  // ---------------------------------------------------------------
  // Next state: result stages and register bus
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // RL11 result stage with its own enable and clear.
    if (stage_in.rst_p) begin
      st_nxt.p = '0;
      st_nxt.fl = '0;
    end else if (stage_in.ce_p) begin
      st_nxt.p = r;
      st_nxt.fl.m = match;
      st_nxt.fl.mb = hit(r, ~st_r.pat, st_r.mask);
      // RL9 chaining ANDs this match with the previous one for 96 bits.
      st_nxt.fl.m96 = st_r.cfg.chain ? (match & st_r.fl.m) : match;
      st_nxt.fl.xr = xr;
    end
    // RL11 optional output stage, costing one more cycle of latency.
    if (stage_in.rst_q) begin
      st_nxt.q = '0;
      st_nxt.qfl = '0;
    end else if (stage_in.ce_q) begin
      st_nxt.q = st_r.p;
      st_nxt.qfl = st_r.fl;
    end
    // Data phase of a write takes the word captured one cycle later.
    if (st_r.ah_act && st_r.ah_wr) begin
      case (st_r.ah_addr)
        OFF_CFG: st_nxt.cfg = cfg_s'(hwdata[7:0]);
        OFF_PAT_LO: st_nxt.pat[31:0] = hwdata;
        OFF_PAT_HI: st_nxt.pat[P_W-1:32] = hwdata[P_W-33:0];
        OFF_MASK_LO: st_nxt.mask[31:0] = hwdata;
        OFF_MASK_HI: st_nxt.mask[P_W-1:32] = hwdata[P_W-33:0];
        OFF_STEP: st_nxt.step = hwdata;
        default: st_nxt.step = st_nxt.step;
      endcase
    end
    // Only whole-word transfers are decoded; others complete but do nothing.
    st_nxt.ah_act = hsel && htrans[1] && hready && hsize == HSIZE_WORD;
    st_nxt.ah_wr = hwrite;
    st_nxt.ah_addr = haddr[7:0];
    // Read data is fetched at the address phase from the post-write view,
    // so a read right after a write returns the new value.
    if (st_nxt.ah_act && !hwrite) begin
      st_nxt.rdata = read_reg(haddr[7:0], st_nxt);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.cfg <= cfg_s'(CFG_RST);
      st_r.pat <= PAT_RST;
      st_r.mask <= MASK_RST;
      st_r.step <= STEP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Zero-wait slave: every transfer ends in one data-phase cycle.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign p_out = st_r.cfg.q_reg ? st_r.q : st_r.p;
  assign flags_out = st_r.cfg.q_reg ? st_r.qfl : st_r.fl;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_mult_plus_c: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    stage_in.ce_p && !stage_in.rst_p && m_q.ctrl.op == OP_ADD && !m_q.ctrl.acc
    && !m_q.ctrl.bypass && st_r.cfg.simd == SIMD_ONE48
    |=> st_r.p == $past(m_q.prod + m_q.c)) else $error("product sum wrong");
  a_acc_sum: assert property (@(posedge clk) disable iff (!rst_n) // RL2
    stage_in.ce_p && !stage_in.rst_p && m_q.ctrl.op == OP_ADD && m_q.ctrl.acc
    && st_r.cfg.simd == SIMD_ONE48
    |=> st_r.p == $past(st_r.p + x + y)) else $error("accumulate wrong");
  a_acc_hold: assert property (@(posedge clk) disable iff (!rst_n) // RL2
    !stage_in.ce_p && !stage_in.rst_p |=> $stable(st_r.p)) else $error("result moved");
  a_bypass_sum: assert property (@(posedge clk) disable iff (!rst_n) // RL3
    stage_in.ce_p && !stage_in.rst_p && m_q.ctrl.op == OP_ADD && !m_q.ctrl.acc
    && m_q.ctrl.bypass && st_r.cfg.simd == SIMD_ONE48
    |=> st_r.p == $past(m_q.ab + m_q.c)) else $error("bypass sum wrong");
  a_lane_split: assert property (@(posedge clk) disable iff (!rst_n) // RL4
    stage_in.ce_p && !stage_in.rst_p && m_q.ctrl.op == OP_ADD && !m_q.ctrl.acc
    && m_q.ctrl.bypass && st_r.cfg.simd == SIMD_FOUR12
    |=> st_r.p[23:12] == $past(m_q.ab[23:12] + m_q.c[23:12])) else $error("lane carry leak");
  a_logic_xor: assert property (@(posedge clk) disable iff (!rst_n) // RL5
    stage_in.ce_p && !stage_in.rst_p && m_q.ctrl.op == OP_LOGIC && m_q.ctrl.fn == FN_XOR
    |=> st_r.p == $past(x ^ y)) else $error("logic xor wrong");
  a_preadd_prod: assert property (@(posedge clk) disable iff (!rst_n) // RL6
    st_r.cfg.m_reg && stage_in.ce_m && !stage_in.rst_m && in_q.ctrl.preadd
    && !in_q.ctrl.pre_sub
    |=> $signed(m_q.prod) == $past(($signed(sext(in_q.d)) + $signed(sext(in_q.a)))
                                   * $signed(P_W'($signed(in_q.b)))))
    else $error("pre-add product wrong");
  a_xor_full: assert property (@(posedge clk) disable iff (!rst_n) // RL7
    stage_in.ce_p && !stage_in.rst_p && st_r.cfg.xw == XW_96
    |=> st_r.fl.xr == {7'h0, $past(^{x, y})}) else $error("wide xor wrong");
  a_pattern_flag: assert property (@(posedge clk) disable iff (!rst_n) // RL8
    stage_in.ce_p && !stage_in.rst_p
    |=> st_r.fl.m == hit(st_r.p, $past(st_r.pat), $past(st_r.mask))) else $error("match wrong");
  a_chain_match: assert property (@(posedge clk) disable iff (!rst_n) // RL9
    stage_in.ce_p && !stage_in.rst_p && st_r.cfg.chain
    |=> st_r.fl.m96 == ($past(match) && $past(st_r.fl.m))) else $error("chain wrong");
  // Each step is taken from its own cycle, so a step write mid-count is allowed.
  a_count_up: assert property (@(posedge clk) disable iff (!rst_n) // RL10
    stage_in.ce_p && !stage_in.rst_p && m_q.ctrl.op == OP_CNT_UP
    ##1 stage_in.ce_p && !stage_in.rst_p && m_q.ctrl.op == OP_CNT_UP
    |=> st_r.p == $past(st_r.p, 2) + P_W'($past(st_r.step, 2)) + P_W'($past(st_r.step)))
    else $error("count wrong");
  a_result_clear: assert property (@(posedge clk) disable iff (!rst_n) // RL11
    stage_in.rst_p |=> st_r.p == '0 && st_r.fl == '0) else $error("result not cleared");
  a_out_stage: assert property (@(posedge clk) disable iff (!rst_n) // RL11
    stage_in.ce_q && !stage_in.rst_q |=> st_r.q == $past(st_r.p) && st_r.qfl == $past(st_r.fl))
    else $error("output stage wrong");

endmodule : dsp_slice

//--- fabric_model.sv
// Model of the fabric logic that feeds operands and stage controls to the slice.
// Assumes one shared clock; the caller picks the hold time from the configured latency.
`timescale 1ns/1ns
module fabric_model
  import dsp_slice_pkg::*;
(
  input wire logic clk,
  output opnd_s opnd_o,
  output stage_s stage_o
);
  // Idle values at time zero, all stages disabled.
  initial begin
    opnd_o = '0;
    stage_o = '0;
  end

  // controls with operands.
  // Operands and controls change together just after an edge and stand for hold edges,
  // long enough to cover the pipeline depth. Afterwards the stage controls clear and every operand bit flips, so a stage that
  // samples without its enable picks up garbage instead of a value that still looks right.
  task send(input opnd_s o, input stage_s s, input int hold);
    @(posedge clk);
    opnd_o <= o;
    stage_o <= s;
    repeat (hold) @(posedge clk);
    stage_o <= '0;
    opnd_o <= ~o;
  endtask : send
endmodule : fabric_model

//--- dsp_slice_tb.sv
// Self-checking bench for the multiply-accumulate slice.
// Assumes hready is the slave's own hreadyout and operands come from fabric_model.
`timescale 1ns/1ns
module dsp_slice_tb
  import dsp_slice_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [47:0] p_out;
  flags_s flags_out;
  opnd_s opnd;
  stage_s stage;
  int n_errors = 0;
  int checks_done = 0;
  int i, j, k, w;
  logic [31:0] rd;
  logic [47:0] e, x, y;
  logic [95:0] v;
  localparam logic [47:0] PT = 48'h1234_5678_9abc;

  // 25 MHz clock.
  always #20 clk = ~clk;

  fabric_model fab (.clk(clk), .opnd_o(opnd), .stage_o(stage));

  dsp_slice uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .opnd_in(opnd),
    .stage_in(stage), .p_out(p_out), .flags_out(flags_out));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task end_of_test;
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task chk(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Bounded wait for hready; a stuck bus ends the run as a failure.
  task wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_errors++;
        end_of_test;
      end
      @(posedge clk);
    end
  endtask : wait_rdy

  // One single AHB-Lite word transfer; read data is taken at the data-phase edge.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    r = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    chk(48'(rd), 48'(exp));
  endtask : rdc

  function automatic logic [47:0] mul(input logic [26:0] a, input logic [17:0] b);
    logic signed [47:0] sa, sb;
    sa = $signed(a);
    sb = $signed(b);
    return sa * sb;
  endfunction : mul

  // Flags f are {bypass, preadd, pre_sub, acc}.
  function automatic opnd_s mk(input logic [47:0] ab, input logic [47:0] c, input logic [3:0] f,
      input alu_op_e op, input logic_fn_e fn, input logic [26:0] a, input logic [17:0] b,
      input logic [26:0] d);
    mk = '{a: a, b: b, d: d, ab: ab, c: c, ctrl: '{f[3], f[2], f[1], f[0], op, fn}};
  endfunction : mk

  function automatic opnd_s bx(input logic [47:0] ab, input logic [47:0] c, input alu_op_e op);
    return mk(ab, c, 4'b1000, op, FN_AND, 27'h0, 18'h0, 27'h0);
  endfunction : bx

  task go(input opnd_s o, input logic [7:0] s, input int h, input logic [47:0] exp);
    fab.send(o, stage_s'(s), h);
    #1;
    chk(p_out, exp);
  endtask : go

  task fl(input logic [47:0] ab, input logic [2:0] exp);
    fab.send(bx(ab, 48'h0, OP_ADD), stage_s'(8'haa), 1);
    #1;
    chk(48'(flags_out[2:0]), 48'(exp));
  endtask : fl

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk(p_out, 48'h0);
    rdc(OFF_CFG, 32'h0);
    rdc(OFF_STEP, 32'h1);
    wr(8'h24, 32'hdead_beef);
    rdc(8'h24, 32'h0);
    chk(48'(hresp), 48'h0);
    chk(48'(hreadyout), 48'h1);
    go(mk(48'h0, 48'h0, 4'h0, OP_ADD, FN_AND, 27'h7fffffd, 18'h5, 27'h0), 8'haa, 1,
       mul(27'h7fffffd, 18'h5));
    go(mk(48'h0, 48'h0, 4'h0, OP_ADD, FN_AND, 27'h4000000, 18'h20000, 27'h0), 8'haa, 1,
       mul(27'h4000000, 18'h20000));
    rdc(OFF_RES_HI, 32'h800);
    go(mk(48'h0, 48'h0, 4'b0100, OP_ADD, FN_AND, 27'h3, 18'h7, 27'ha), 8'haa, 1, 48'd91);
    go(mk(48'h0, 48'h0, 4'b0110, OP_ADD, FN_AND, 27'ha, 18'h7, 27'h3), 8'haa, 1,
       48'hffff_ffff_ffcf);
    // multiplier skipped; product of a and b must not appear.
    go(mk(PT, 48'h1111_1111_1111, 4'b1000, OP_ADD, FN_AND, 27'h5, 18'h5, 27'h0), 8'haa, 1,
       48'h2345_6789_abcd);
    go(mk(PT, 48'h1111_1111_1111, 4'b1000, OP_SUB, FN_AND, 27'h5, 18'h5, 27'h0), 8'haa, 1,
       48'hdcba_9876_5433);
    // back-to-back accumulation after a stage clear.
    go(bx(48'h0, 48'h0, OP_ADD), 8'h04, 1, 48'h0);
    go(mk(48'h0100_0001, 48'h0fff, 4'b1001, OP_ADD, FN_AND, 27'h0, 18'h0, 27'h0), 8'haa, 2,
       48'h0200_2000);
    go(mk(48'h0100_0001, 48'h0fff, 4'b1001, OP_SUB, FN_AND, 27'h0, 18'h0, 27'h0), 8'haa, 1,
       48'h0100_1000);
    // counting through zero with a set step.
    wr(OFF_STEP, 32'h5);
    go(bx(48'h0, 48'h0, OP_ADD), 8'h04, 1, 48'h0);
    go(bx(48'h0, 48'h0, OP_CNT_UP), 8'haa, 3, 48'hf);
    go(bx(48'h0, 48'h0, OP_CNT_DN), 8'haa, 1, 48'ha);
    go(bx(48'h0, 48'h0, OP_CNT_DN), 8'haa, 3, 48'hffff_ffff_fffb);
    // lanes keep their carries and borrows.
    wr(OFF_CFG, 32'h8);
    go(bx(48'h0000_01ff_ffff, 48'h1, OP_ADD), 8'haa, 1, 48'h0000_0100_0000);
    go(bx(48'h0, 48'h0000_0100_0001, OP_SUB), 8'haa, 1, 48'hffff_ffff_ffff);
    wr(OFF_CFG, 32'h10);
    go(bx(48'hffff_ffff_ffff, 48'h0010_0100_1001, OP_ADD), 8'haa, 1, 48'h0);
    wr(OFF_CFG, 32'h0);
    x = 48'hff00_ff00_f0f0;
    y = 48'hf0f0_f0f0_cccc;
    for (k = 0; k < 10; k++) begin
      case (k)
        0: e = x & y;
        1: e = x | y;
        2: e = x ^ y;
        3: e = ~(x ^ y);
        4: e = ~(x & y);
        5: e = ~(x | y);
        6: e = x & ~y;
        7: e = x | ~y;
        8: e = ~x;
        default: e = x;
      endcase
      go(mk(x, y, 4'b1000, OP_LOGIC, logic_fn_e'(k), 27'h0, 18'h0, 27'h0), 8'haa, 1, e);
    end
    v = {x, y};
    for (k = 0; k < 4; k++) begin
      wr(OFF_CFG, 32'(k) << 5);
      w = 12 << k;
      e = 48'h0;
      for (i = 0; i < 96 / w; i++) for (j = 0; j < w; j++) e[i] = e[i] ^ v[i * w + j];
      fab.send(bx(x, y, OP_ADD), stage_s'(8'haa), 1);
      #1;
      chk(48'(flags_out.xr), e);
    end
    // masked match against the pattern and its inverse.
    wr(OFF_CFG, 32'h0);
    wr(OFF_PAT_LO, 32'h5678_9abc);
    wr(OFF_PAT_HI, 32'h1234);
    rdc(OFF_PAT_HI, 32'h1234);
    fl(PT, 3'b101);
    fl(PT ^ 48'h5a, 3'b000);
    wr(OFF_MASK_LO, 32'hff);
    fl(PT ^ 48'h5a, 3'b101);
    fl(~PT, 3'b010);
    // chained match needs two matching loads in a row.
    wr(OFF_CFG, 32'h80);
    fl(PT, 3'b001);
    fl(PT, 3'b101);
    fl(PT ^ 48'h100, 3'b000);
    fl(PT, 3'b001);
    // full pipeline: four edges, clear wins over enable, disabled stages hold.
    wr(OFF_CFG, 32'h7);
    go(bx(48'h0, 48'h0, OP_ADD), 8'hff, 1, 48'h0);
    fab.send(mk(48'h0, 48'h0, 4'h0, OP_ADD, FN_AND, 27'h3, 18'h5, 27'h0), stage_s'(8'haa), 3);
    #1;
    chk(p_out, 48'h0);
    rdc(OFF_RES_LO, 32'd15);
    go(bx(48'h0, 48'h0, OP_ADD), 8'hff, 1, 48'h0);
    go(mk(48'h0, 48'h0, 4'b0100, OP_ADD, FN_AND, 27'h1, 18'h5, 27'h2), 8'haa, 4, 48'd15);
    repeat (3) @(posedge clk);
    #1;
    chk(p_out, 48'd15);
    end_of_test;
  end
endmodule : dsp_slice_tb
